// ### rtl/pcr_defines.svh
// Constants of the configuration row map and the preload chain.
// Assumes inclusion by the row store module pcr_rows.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// ----------------------------------------------------------------
// Row addresses
// ----------------------------------------------------------------
`define PCR_ROW_ARRAY_LAST 6'h1f
`define PCR_ROW_SIG 6'h20
`define PCR_ROW_RSV_FIRST 6'h21
`define PCR_ROW_RSV_LAST 6'h3b
`define PCR_ROW_ARCH 6'h3c
`define PCR_ROW_SEC 6'h3d
`define PCR_ROW_ERASE 6'h3f

// ----------------------------------------------------------------
// Architecture word field positions
// ----------------------------------------------------------------
`define PCR_ARCH_POL_LSB 0
`define PCR_ARCH_CELL_LSB 8
`define PCR_ARCH_SYNC_POS 16
`define PCR_ARCH_GLOBAL_POS 17

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCR_ROW_RESET 64'h0000_0000_0000_0000
`define PCR_ARCH_RESET 82'h0
`define PCR_MC_RESET 8'h00

`endif

// ### rtl/pcr_pkg.sv
// Types of the configuration row block.
// Assumes the defines header lies on the include path.
package pcr_pkg;
	// Row data word, architecture word and row address widths
	typedef logic [63:0] pcr_row_t;
	typedef logic [81:0] pcr_arch_t;
	typedef logic [5:0] pcr_addr_t;

	// Programming command from the fixture
	typedef struct packed {
		logic prog;
		logic read;
		pcr_addr_t row;
		pcr_row_t wdata;
		pcr_arch_t wdata_arch;
	} pcr_cmd_s;

	// Preload input pins after synchronising
	typedef struct packed {
		logic enable;
		logic shift_clk;
		logic data;
	} pcr_pre_s;

	// Chain engine modes
	typedef enum logic [1:0] {
		PCR_RUN = 2'b00,
		PCR_PRELOAD = 2'b01
	} pcr_mode_e;
endpackage

// ### rtl/pcr_sync3.sv
// Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes a pin level asynchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pcr_sync3 (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Pin and filtered level
	input wire logic i_pin,
	output logic o_level
);
	// All flops of the synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} pcr_sync_s;

	pcr_sync_s st_reg;
	pcr_sync_s st_next;

	// Level changes only once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = i_pin;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
	end

	// Register stage
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.lvl;
endmodule
`default_nettype wire

// ### rtl/pcr_rows.sv
// Configuration row store, bulk erase, security and preload chain.
// Assumes a fixture issuing one-cycle program or read strobes and
// driving the preload pins asynchronously to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "pcr_defines.svh"
module pcr_rows (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Row access port
	input wire logic [5:0] i_row_addr,
	input wire logic [81:0] i_row_wdata,
	input wire logic i_row_wr,
	input wire logic i_row_rd,
	output logic [81:0] o_row_rdata,
	output logic o_row_denied,
	// Preload pins
	input wire logic i_preload_enable_pin,
	input wire logic i_preload_shift_clock,
	input wire logic i_preload_sdin,
	output logic o_preload_sdout,
	output logic o_preload_sdout_oe_n,
	// Normal function path
	input wire logic [7:0] i_next_state,
	output logic [7:0] o_macrocell_pin,
	output logic o_secured
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Whole module state held in one record
	typedef struct packed {
		logic [31:0][63:0] arr;
		pcr_pkg::pcr_row_t sig;
		pcr_pkg::pcr_arch_t arch;
		logic sec;
		logic [7:0] q;
		logic [81:0] rdata;
		logic denied;
		logic sclk_d;
		logic sdout;
		logic sdout_oe_n;
		logic [7:0] pin;
		pcr_pkg::pcr_mode_e mode;
	} pcr_state_s;

	pcr_state_s st_reg;
	pcr_state_s st_next;
	pcr_pkg::pcr_pre_s pre;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Preload enable pin
	pcr_sync3 u_sync_en (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_preload_enable_pin),
		.o_level(pre.enable)
	);
	// Shift clock pin, edges detected on the filtered level
	pcr_sync3 u_sync_clk (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_preload_shift_clock),
		.o_level(pre.shift_clk)
	);
	// Serial data pin
	pcr_sync3 u_sync_din (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin(i_preload_sdin),
		.o_level(pre.data)
	);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	logic is_array;
	logic sync_mode;
	logic [7:0] registered;
	logic shift_edge;

	// Registered cells follow the architecture word
	always_comb begin
		is_array = (i_row_addr <= `PCR_ROW_ARRAY_LAST);
		// Sync-mode bit low gives registered capability
		sync_mode = st_reg.arch[`PCR_ARCH_SYNC_POS];
		// Registered when global set and cell bit clear, sync mode low
		for (int i = 0; i < 8; i++) begin
			registered[i] = !sync_mode && st_reg.arch[`PCR_ARCH_GLOBAL_POS]
				&& !st_reg.arch[`PCR_ARCH_CELL_LSB + i];
		end
		shift_edge = pre.shift_clk && !st_reg.sclk_d;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Row access, erase and preload chain in one process
	always_comb begin
		logic carry;
		carry = 1'b0;
		st_next = st_reg;
		st_next.denied = 1'b0;
		st_next.sclk_d = pre.shift_clk;
		st_next.rdata = 82'h0;

		// Row program cycle; unknown rows are ignored
		if (i_row_wr) begin
			if (i_row_addr == `PCR_ROW_ERASE) begin
				// Bulk erase returns the part to blank state
				st_next.arr = '0;
				st_next.sig = `PCR_ROW_RESET;
				st_next.arch = `PCR_ARCH_RESET;
				st_next.sec = 1'b0;
			end else if (is_array) begin
				// Secured array refuses programming
				if (st_reg.sec) begin
					st_next.denied = 1'b1;
				end else begin
					st_next.arr[i_row_addr[4:0]] = i_row_wdata[63:0];
				end
			end else if (i_row_addr == `PCR_ROW_SIG) begin
				st_next.sig = i_row_wdata[63:0];
			end else if (i_row_addr == `PCR_ROW_ARCH) begin
				st_next.arch = i_row_wdata;
			end else if (i_row_addr == `PCR_ROW_SEC) begin
				// Only set here; clearing needs a bulk erase
				st_next.sec = st_reg.sec | i_row_wdata[0];
			end
		end

		// Verify readback, data in the following cycle
		if (i_row_rd) begin
			if (is_array) begin
				if (st_reg.sec) begin
					st_next.denied = 1'b1;
				end else begin
					st_next.rdata = {18'h0, st_reg.arr[i_row_addr[4:0]]};
				end
			end else if (i_row_addr == `PCR_ROW_SIG) begin
				// Signature reads ignore the security bit
				st_next.rdata = {18'h0, st_reg.sig};
			end else if (i_row_addr == `PCR_ROW_ARCH) begin
				st_next.rdata = st_reg.arch;
			end else if (i_row_addr == `PCR_ROW_SEC) begin
				st_next.rdata = {81'h0, st_reg.sec};
			end
		end

		// Mode follows the preload pin
		st_next.mode = pre.enable ? pcr_pkg::PCR_PRELOAD : pcr_pkg::PCR_RUN;
		// Serial out buffer driven only in preload
		st_next.sdout_oe_n = !pre.enable;

		unique case (st_reg.mode)
			pcr_pkg::PCR_PRELOAD: begin
				// Shift chain: bit enters lowest registered cell
				if (shift_edge) begin
					carry = pre.data;
					for (int i = 0; i < 8; i++) begin
						if (registered[i]) begin
							st_next.q[i] = carry;
							carry = st_reg.q[i];
						end
					end
					// Bit leaving the top of the chain
					st_next.sdout = carry;
				end
			end
			pcr_pkg::PCR_RUN: begin
				// Normal clocking of registered cells
				for (int i = 0; i < 8; i++) begin
					if (registered[i]) begin
						st_next.q[i] = i_next_state[i];
					end
				end
			end
			default: begin
				st_next.mode = pcr_pkg::PCR_RUN;
			end
		endcase

		// Output pins: registered cells show Q inverted, other cells apply polarity
		for (int i = 0; i < 8; i++) begin
			if (registered[i]) begin
				// Q low after reset shows high regardless of polarity
				st_next.pin[i] = !st_next.q[i];
			end else begin
				// Polarity 1 active high, 0 active low
				st_next.pin[i] = st_reg.arch[`PCR_ARCH_POL_LSB + i] ? i_next_state[i]
					: !i_next_state[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register stage
	// ----------------------------------------------------------------
	// Reset clears every Q; pins of registered cells then read high
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
			st_reg.sdout_oe_n <= 1'b1;
			st_reg.pin <= 8'hff;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign o_row_rdata = st_reg.rdata;
	assign o_row_denied = st_reg.denied;
	assign o_preload_sdout = st_reg.sdout;
	assign o_preload_sdout_oe_n = st_reg.sdout_oe_n;
	assign o_macrocell_pin = st_reg.pin;
	assign o_secured = st_reg.sec;
endmodule
`default_nettype wire

// ### tb/pcr_rows_properties.sv
// Checker for the row bus, security cell and preload pins of pcr_rows.
// Assumes it is bound onto pcr_rows and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module pcr_rows_properties (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Row bus
	input wire logic [5:0] i_row_addr,
	input wire logic [81:0] i_row_wdata,
	input wire logic i_row_wr,
	input wire logic i_row_rd,
	input wire logic [81:0] o_row_rdata,
	input wire logic o_row_denied,
	input wire logic o_secured,
	// Preload pins
	input wire logic i_preload_enable_pin,
	input wire logic o_preload_sdout_oe_n
);
	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Array access while the lock is set
	sequence s_locked;
		(i_row_rd || i_row_wr) && i_row_addr <= 6'h1f && o_secured;
	endsequence
	// Program cycle on the erase row
	sequence s_erase;
		i_row_wr && i_row_addr == 6'h3f;
	endsequence
	a_read_idle: assert property (!i_row_rd |=> o_row_rdata == 82'h0)
		else $error("read data outside a read slot");
	a_locked_deny: assert property (s_locked |=> o_row_denied && o_row_rdata == 82'h0)
		else $error("locked array access not refused");
	a_deny_cause: assert property (o_row_denied |-> $past(o_secured) && $past(i_row_addr) <= 6'h1f)
		else $error("refusal without locked array access");
	a_sig_open: assert property (i_row_rd && i_row_addr == 6'h20 |=> !o_row_denied)
		else $error("signature read refused");
	a_lock_set: assert property (i_row_wr && i_row_addr == 6'h3d && i_row_wdata[0] |=> o_secured)
		else $error("lock not set");
	a_lock_hold: assert property (o_secured && !(i_row_wr && i_row_addr == 6'h3f) |=> o_secured)
		else $error("lock lost without erase");
	a_lock_cause: assert property (!o_secured && !(i_row_wr && i_row_addr == 6'h3d) |=> !o_secured)
		else $error("lock set without a program cycle");
	a_erase_clear: assert property (s_erase |=> !o_secured ##1 !o_row_denied)
		else $error("erase left the lock set");
	a_pre_on: assert property (i_preload_enable_pin [*8] |-> !o_preload_sdout_oe_n)
		else $error("serial out not driven in preload");
	a_pre_off: assert property (!i_preload_enable_pin [*8] |-> o_preload_sdout_oe_n)
		else $error("serial out driven outside preload");
endmodule
bind pcr_rows pcr_rows_properties pcr_rows_properties_i (
	.i_sys_clk, .i_rst_n, .i_row_addr, .i_row_wdata, .i_row_wr, .i_row_rd, .o_row_rdata,
	.o_row_denied, .o_secured, .i_preload_enable_pin, .o_preload_sdout_oe_n
);
`default_nettype wire

// ### tb/pcr_fixture.sv
// Model of the programming fixture that drives rows and preload pins.
// Assumes one clock shared with the device; all changes follow a rising edge.
`timescale 1ns/100ps
`default_nettype none
module pcr_fixture (
	// Clock
	input wire logic i_sys_clk,
	// Row bus
	output logic [5:0] o_addr,
	output logic [81:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	// Preload pins
	output logic o_pen,
	output logic o_pck,
	output logic o_sdin
);
	logic busy = 1'b0;
	initial begin
		o_addr = 6'h00;
		o_wdata = 82'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_pen = 1'b0;
		o_pck = 1'b0;
		o_sdin = 1'b0;
	end
	// Idle serial data toggles, so a stale bit can never pass as a shifted one
	always @(posedge i_sys_clk) begin
		if (!busy) begin
			o_sdin <= ~o_sdin;
		end
	end
	// One program cycle; reserved rows are never addressed
	task automatic put(input logic [5:0] a, input logic [81:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	// One read cycle
	task automatic get(input logic [5:0] a);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
	endtask
	// Enter or leave preload, then let the synchroniser settle
	task automatic mode(input logic on);
		@(posedge i_sys_clk);
		o_pen <= on;
		repeat (8) @(posedge i_sys_clk);
	endtask
	// Long phases so each shift clock level survives the pin filter
	task automatic shift(input logic b);
		busy = 1'b1;
		@(posedge i_sys_clk);
		o_sdin <= b;
		repeat (6) @(posedge i_sys_clk);
		o_pck <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		o_pck <= 1'b0;
		repeat (6) @(posedge i_sys_clk);
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb/pld_config_rows_preload_tb_top.sv
// Self-checking bench for pcr_rows against a row map model.
// Assumes the fixture model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module pld_config_rows_preload_tb_top;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_next_state = 8'h00;
	wire [5:0] i_row_addr;
	wire [81:0] i_row_wdata, o_row_rdata;
	wire i_row_wr, i_row_rd, o_row_denied, o_secured;
	wire i_preload_enable_pin, i_preload_shift_clock, i_preload_sdin;
	wire o_preload_sdout, o_preload_sdout_oe_n;
	wire [7:0] o_macrocell_pin;
	int n_errors = 0;
	int checked = 0;
	logic [81:0] mem [64] = '{default: 82'h0};
	logic [81:0] v;
	logic b;
	bit sec;
	bit q[$];
	pcr_rows pcr_rows_i (.*);
	pcr_fixture pcr_fixture_i (.i_sys_clk, .o_addr(i_row_addr), .o_wdata(i_row_wdata),
		.o_wr(i_row_wr), .o_rd(i_row_rd), .o_pen(i_preload_enable_pin),
		.o_pck(i_preload_shift_clock), .o_sdin(i_preload_sdin));
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// ----------------------------------------------------------------
	// Checking tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [81:0] seen, input logic [81:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Program a row and update the model as the lock allows
	task automatic wr_m(input logic [5:0] a, input logic [81:0] d);
		pcr_fixture_i.put(a, d);
		#1;
		chk(o_row_denied, sec && a <= 6'h1f);
		if (a == 6'h3f) begin
			mem = '{default: 82'h0};
			sec = 1'b0;
		end else if (a == 6'h3d) begin
			sec = sec | d[0];
		end else if (!(sec && a <= 6'h1f)) begin
			mem[a] = (a == 6'h3c) ? d : {18'h0, d[63:0]};
		end
		chk(o_secured, sec);
	endtask
	// Read every user row back; the array is hidden while locked
	task automatic rd_all;
		for (int r = 0; r <= 60; r++) begin
			if (r <= 32 || r == 60) begin
				pcr_fixture_i.get(6'(r));
				#1;
				chk(o_row_rdata, (sec && r <= 31) ? 82'h0 : mem[r]);
				chk(o_row_denied, sec && r <= 31);
			end
		end
	endtask
	// Set the control word, then drive next-state values through the cells
	task automatic cell_run(input logic sync, input logic [7:0] cells, input logic [7:0] pol);
		wr_m(6'h3c, {64'h0, 1'b1, sync, cells, pol});
		repeat (3) begin
			@(posedge i_sys_clk);
			i_next_state <= 8'($urandom());
			repeat (3) @(posedge i_sys_clk);
			#1;
			// Combinational cells follow polarity, registered cells show inverted Q
			chk(o_macrocell_pin, 8'(((i_next_state ^ ~pol) & ({8{sync}} | cells))
				| (~i_next_state & ~({8{sync}} | cells))));
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(38));
		// Inputs settle well before the first clocked access after reset
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		#1;
		chk(o_macrocell_pin, 8'hff);
		chk(o_preload_sdout_oe_n, 1'b1);
		for (int r = 0; r <= 32; r++) begin
			wr_m(6'(r), 82'({$urandom(), $urandom(), $urandom()}));
		end
		wr_m(6'h3c, 82'({$urandom(), $urandom(), $urandom()}));
		rd_all();
		cell_run(1'b1, 8'h00, 8'($urandom()));
		cell_run(1'b0, 8'h00, 8'($urandom()));
		// Upper four cells combinational: the chain is four bits long
		cell_run(1'b0, 8'hf0, 8'h5a);
		pcr_fixture_i.mode(1'b1);
		#1;
		chk(o_preload_sdout_oe_n, 1'b0);
		repeat (8) begin
			b = 1'($urandom());
			pcr_fixture_i.shift(b);
			#1;
			if (q.size() == 4) begin
				chk(o_preload_sdout, q.pop_front());
			end
			q.push_back(b);
		end
		chk(o_macrocell_pin[3:0], 4'(~{q[0], q[1], q[2], q[3]}));
		pcr_fixture_i.mode(1'b0);
		#1;
		chk(o_preload_sdout_oe_n, 1'b1);
		wr_m(6'h3d, 82'h1);
		wr_m(6'h03, 82'h3);
		rd_all();
		wr_m(6'h3f, 82'h0);
		rd_all();
		print_verdict();
	end
	// Watchdog far beyond the roughly 500 cycles the tests need
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
